//--- wdt_pkg.sv
package wdt_pkg;

	// ------------------------------------------------------------
	// clock rates
	// ------------------------------------------------------------
	localparam int unsigned SYS_CLK_FREQ_MHZ = 200;
	localparam int unsigned RCOSC_FREQ_KHZ = 32;
	// system clock cycles per nominal oscillator period
	localparam int unsigned RCOSC_TICK_CYCLES_DFLT = (SYS_CLK_FREQ_MHZ * 1000) / RCOSC_FREQ_KHZ;
	localparam int unsigned RCOSC_CNT_W = 16;

	// ------------------------------------------------------------
	// prescaler and postscaler shape
	// ------------------------------------------------------------
	localparam int unsigned PRE_W = 7;
	localparam int unsigned POST_W = 15;
	localparam int unsigned POST_SEL_W = 4;
	localparam int unsigned ELAPSED_W = 23;
	// terminal counts: divide by 32 and divide by 128
	localparam logic [PRE_W-1:0] PRE_LIMIT_DIV32 = 7'h1F;
	localparam logic [PRE_W-1:0] PRE_LIMIT_DIV128 = 7'h7F;
	localparam logic [ELAPSED_W-1:0] PRE_RATIO_DIV32 = 23'h000020;
	localparam logic [ELAPSED_W-1:0] PRE_RATIO_DIV128 = 23'h000080;
	// nominal prescaler output periods
	localparam int unsigned PRE_PERIOD_DIV32_MS = 1;
	localparam int unsigned PRE_PERIOD_DIV128_MS = 4;
	localparam logic [POST_W:0] POST_ONE = 16'h0001;

	// ------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------
	localparam logic RST_SW_ENABLE = 1'b0;
	localparam logic RST_FLAG = 1'b0;
	localparam logic RST_PULSE = 1'b0;

	// ------------------------------------------------------------
	// power-save state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		WDT_ST_RUN = 3'b001,
		WDT_ST_SLEEP = 3'b010,
		WDT_ST_IDLE = 3'b100
	} wdt_state_t;

endpackage

//--- wdt_low_power_rc_osc_osc.sv
`timescale 1ns/100ps
module wdt_rcosc
	import wdt_pkg::*;
#(
	parameter int unsigned CYCLES = RCOSC_TICK_CYCLES_DFLT
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// control
	input wire logic enable,
	// one pulse per oscillator period
	output logic tick
);

	// ------------------------------------------------------------
	// period counter
	// ------------------------------------------------------------
	logic [RCOSC_CNT_W-1:0] cnt_r;
	logic [RCOSC_CNT_W-1:0] cnt_nxt;
	logic tick_r;
	logic tick_nxt;

	localparam logic [RCOSC_CNT_W-1:0] LAST = RCOSC_CNT_W'(CYCLES - 1);

	always_comb begin
		cnt_nxt = cnt_r;
		tick_nxt = 1'b0;
		// a stopped oscillator restarts from a full period
		if (!enable) begin
			cnt_nxt = '0;
		end else if (cnt_r >= LAST) begin
			cnt_nxt = '0;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;

endmodule

//--- wdt_divider.sv
`timescale 1ns/100ps
module wdt_divider #(
	parameter int unsigned W = 7
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// count control
	input wire logic clear,
	input wire logic tick_in,
	input wire logic [W-1:0] limit,
	// state
	output logic [W-1:0] count,
	output logic tick_out
);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic wrap;

	// >= so a smaller limit chosen mid-count cannot run past it
	assign wrap = (cnt_r >= limit);

	always_comb begin
		cnt_nxt = cnt_r;
		if (clear) begin
			cnt_nxt = '0;
		end else if (tick_in) begin
			cnt_nxt = wrap ? '0 : cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign count = cnt_r;
	// not masked by clear: the clear is built from this tick upstream, and a
	// clear in the same cycle must not swallow a time-out
	assign tick_out = tick_in & wrap;

endmodule

//--- wdt_watchdog_timer.sv
// Function
// - counter runs on the low-power oscillator; enabling the watchdog starts it
// - 32 kHz clock feeds a divide-by-32 or divide-by-128 prescaler
// - prescaler output period is about 1 ms or about 4 ms
// - 4-bit field picks one of 16 postscaler ratios, 1:1 to 1:32768
// - counters clear on any device reset and on clock switch completion
// - counters clear on entering and again on leaving sleep or idle
// - clear instruction in normal execution resets counter, prescaler and postscaler
// - enabled watchdog counts in sleep/idle; time-out wakes the core
// - sleep and idle status bits stay set until software clears them
// - sticky time-out flag, cleared only by software
// - forced-enable configuration bit keeps the watchdog always on
// - without forced enable, the software enable bit runs the watchdog
// - any device reset clears the software enable bit
// - in window mode a clear before the last quarter causes a reset
// - prescale select 1 divides by 128, 0 divides by 32
// - postscaler ratio is two to the power of the field
// - window-disable 1 means non-window mode, 0 window mode
`timescale 1ns/100ps
module wdt_watchdog_timer
	import wdt_pkg::*;
#(
	parameter int unsigned RCOSC_TICK_CYCLES = RCOSC_TICK_CYCLES_DFLT
) (
	// clock and power-on reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// configuration word
	input wire logic forced_enable_cfg,
	input wire logic window_disable_cfg,
	input wire logic prescale_select,
	input wire logic [POST_SEL_W-1:0] postscale_select,
	// core events, one-cycle pulses
	input wire logic watchdog_clear_instr,
	input wire logic power_save_instr,
	input wire logic power_save_idle,
	input wire logic clock_switch_done,
	input wire logic device_reset_req,
	input wire logic wake_event,
	// software access to reset control bits
	input wire logic software_enable_wr,
	input wire logic software_enable_wdata,
	input wire logic timeout_flag_clr,
	input wire logic sleep_flag_clr,
	input wire logic idle_flag_clr,
	// status
	output logic low_power_rc_osc_en,
	output logic watchdog_active,
	output logic software_enable_bit,
	output logic timeout_flag,
	output logic sleep_flag,
	output logic idle_flag,
	output logic power_save_active,
	output logic window_open,
	// actions toward the core
	output logic core_wake,
	output logic watchdog_reset_req
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	wdt_state_t state_r;
	wdt_state_t state_nxt;
	logic sw_en_r;
	logic sw_en_nxt;
	logic enabled;
	logic osc_en_r;
	logic osc_en_nxt;
	logic active_r;
	logic to_flag_r;
	logic to_flag_nxt;
	logic sleep_r;
	logic sleep_nxt;
	logic idle_r;
	logic idle_nxt;
	logic wake_r;
	logic wake_nxt;
	logic rst_req_r;
	logic rst_req_nxt;
	logic win_r;
	logic win_nxt;
	logic ps_active_r;

	logic rcosc_tick;
	logic pre_tick;
	logic timeout_evt;
	logic [PRE_W-1:0] pre_limit;
	logic [PRE_W-1:0] pre_cnt;
	logic [POST_W-1:0] post_limit;
	logic [POST_W-1:0] post_cnt;
	logic [ELAPSED_W-1:0] elapsed;
	logic [ELAPSED_W-1:0] total;
	logic win_now;
	logic in_run;
	logic enter_ps;
	logic exit_ps;
	logic clr_normal;
	logic early_clear;
	logic counter_clear;

	// ------------------------------------------------------------
	// enable
	// ------------------------------------------------------------
	assign enabled = forced_enable_cfg | sw_en_r;

	always_comb begin
		sw_en_nxt = sw_en_r;
		if (device_reset_req) begin
			sw_en_nxt = RST_SW_ENABLE;
		end else if (software_enable_wr) begin
			sw_en_nxt = software_enable_wdata;
		end
		// forced mode keeps the oscillator on whatever software writes
		osc_en_nxt = forced_enable_cfg | sw_en_nxt;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sw_en_r <= RST_SW_ENABLE;
			osc_en_r <= 1'b0;
			active_r <= 1'b0;
		end else begin
			sw_en_r <= sw_en_nxt;
			osc_en_r <= osc_en_nxt;
			active_r <= enabled;
		end
	end

	// ------------------------------------------------------------
	// counter chain
	// ------------------------------------------------------------
	wdt_rcosc #(
		.CYCLES(RCOSC_TICK_CYCLES)
	) u_osc (
		.clk(sys_clk),
		.reset_n(reset_n),
		.enable(osc_en_r),
		.tick(rcosc_tick)
	);

	// 1 ms or 4 ms per prescaler tick at the nominal rate
	assign pre_limit = prescale_select ? PRE_LIMIT_DIV128 : PRE_LIMIT_DIV32;
	assign post_limit = POST_W'((POST_ONE << postscale_select) - POST_ONE);

	wdt_divider #(
		.W(PRE_W)
	) u_pre (
		.clk(sys_clk),
		.reset_n(reset_n),
		.clear(counter_clear),
		.tick_in(rcosc_tick & enabled),
		.limit(pre_limit),
		.count(pre_cnt),
		.tick_out(pre_tick)
	);

	wdt_divider #(
		.W(POST_W)
	) u_post (
		.clk(sys_clk),
		.reset_n(reset_n),
		.clear(counter_clear),
		.tick_in(pre_tick),
		.limit(post_limit),
		.count(post_cnt),
		.tick_out(timeout_evt)
	);

	// ------------------------------------------------------------
	// clear window
	// ------------------------------------------------------------
	// both ratios are powers of two, so elapsed ticks are a concatenation
	always_comb begin
		if (prescale_select) begin
			elapsed = {1'b0, post_cnt, pre_cnt};
			total = PRE_RATIO_DIV128 << postscale_select;
		end else begin
			elapsed = {3'b000, post_cnt, pre_cnt[4:0]};
			total = PRE_RATIO_DIV32 << postscale_select;
		end
		win_now = (elapsed >= (total - (total >> 2)));
	end

	// ------------------------------------------------------------
	// event decode
	// ------------------------------------------------------------
	assign in_run = (state_r == WDT_ST_RUN);
	assign clr_normal = watchdog_clear_instr & in_run;
	assign early_clear = clr_normal & enabled & ~window_disable_cfg & ~win_now;
	assign enter_ps = in_run & power_save_instr & ~timeout_evt;
	assign exit_ps = ~in_run & (wake_event | timeout_evt);

	// a disabled watchdog restarts from zero when it is enabled again
	assign counter_clear = device_reset_req | clock_switch_done | enter_ps | exit_ps
		| clr_normal | ~enabled;

	// ------------------------------------------------------------
	// power-save state
	// ------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			WDT_ST_RUN: begin
				if (enter_ps) begin
					state_nxt = power_save_idle ? WDT_ST_IDLE : WDT_ST_SLEEP;
				end
			end
			WDT_ST_SLEEP, WDT_ST_IDLE: begin
				// counting carries on here, so a time-out wakes the core
				if (exit_ps) begin
					state_nxt = WDT_ST_RUN;
				end
			end
			default: begin
				state_nxt = WDT_ST_RUN;
			end
		endcase
		if (device_reset_req) begin
			state_nxt = WDT_ST_RUN;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= WDT_ST_RUN;
			ps_active_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ps_active_r <= (state_nxt != WDT_ST_RUN);
		end
	end

	// ------------------------------------------------------------
	// status flags and actions
	// ------------------------------------------------------------
	always_comb begin
		to_flag_nxt = to_flag_r;
		sleep_nxt = sleep_r;
		idle_nxt = idle_r;
		wake_nxt = 1'b0;
		rst_req_nxt = 1'b0;
		// clears first so that a set in the same cycle wins
		if (timeout_flag_clr) begin
			to_flag_nxt = 1'b0;
		end
		if (sleep_flag_clr) begin
			sleep_nxt = 1'b0;
		end
		if (idle_flag_clr) begin
			idle_nxt = 1'b0;
		end
		if (enter_ps & power_save_idle) begin
			idle_nxt = 1'b1;
		end
		if (enter_ps & ~power_save_idle) begin
			sleep_nxt = 1'b1;
		end
		if (timeout_evt) begin
			to_flag_nxt = 1'b1;
			if (in_run) begin
				rst_req_nxt = 1'b1;
			end else begin
				wake_nxt = 1'b1;
			end
		end
		if (early_clear) begin
			to_flag_nxt = 1'b1;
			rst_req_nxt = 1'b1;
		end
		if (wake_event & ~in_run) begin
			wake_nxt = 1'b1;
		end
		win_nxt = enabled & in_run & win_now;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			to_flag_r <= RST_FLAG;
			sleep_r <= RST_FLAG;
			idle_r <= RST_FLAG;
			wake_r <= RST_PULSE;
			rst_req_r <= RST_PULSE;
			win_r <= 1'b0;
		end else begin
			to_flag_r <= to_flag_nxt;
			sleep_r <= sleep_nxt;
			idle_r <= idle_nxt;
			wake_r <= wake_nxt;
			rst_req_r <= rst_req_nxt;
			win_r <= win_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign low_power_rc_osc_en = osc_en_r;
	assign watchdog_active = active_r;
	assign software_enable_bit = sw_en_r;
	assign timeout_flag = to_flag_r;
	assign sleep_flag = sleep_r;
	assign idle_flag = idle_r;
	assign power_save_active = ps_active_r;
	assign window_open = win_r;
	assign core_wake = wake_r;
	assign watchdog_reset_req = rst_req_r;

endmodule

//--- wdt_watchdog_timer_sva.sv
`timescale 1ns/100ps
module wdt_sva
	import wdt_pkg::*;
#(
	parameter int unsigned RCOSC_TICK_CYCLES = RCOSC_TICK_CYCLES_DFLT
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// inputs watched
	input wire logic forced_enable_cfg,
	input wire logic software_enable_wr,
	input wire logic software_enable_wdata,
	input wire logic device_reset_req,
	input wire logic power_save_instr,
	input wire logic power_save_idle,
	input wire logic timeout_flag_clr,
	input wire logic sleep_flag_clr,
	input wire logic idle_flag_clr,
	// outputs watched
	input wire logic low_power_rc_osc_en,
	input wire logic software_enable_bit,
	input wire logic timeout_flag,
	input wire logic sleep_flag,
	input wire logic idle_flag,
	input wire logic power_save_active,
	input wire logic core_wake,
	input wire logic watchdog_reset_req
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// ------------------------------------------------------------
	// sequences
	// ------------------------------------------------------------
	sequence s_enter;
		power_save_instr && !power_save_active && !power_save_idle && !device_reset_req;
	endsequence
	sequence s_asleep;
		sleep_flag && power_save_active;
	endsequence
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	a_forced_osc_on: assert property (forced_enable_cfg |=> low_power_rc_osc_en)
		else $error("oscillator off while forced on");
	a_sw_bit_write: assert property (software_enable_wr && !device_reset_req
		|=> software_enable_bit == $past(software_enable_wdata)) else $error("sw enable lost");
	a_devrst_sw_clear: assert property (device_reset_req |=> !software_enable_bit)
		else $error("sw enable survived reset");
	a_flag_sticky: assert property (timeout_flag && !timeout_flag_clr |=> timeout_flag)
		else $error("time-out flag dropped");
	a_reset_sets_flag: assert property (watchdog_reset_req |-> timeout_flag)
		else $error("reset without flag");
	a_no_reset_saving: assert property (watchdog_reset_req |-> !$past(power_save_active))
		else $error("reset while saving power");
	a_wake_leaves: assert property (core_wake |-> !power_save_active && $past(power_save_active))
		else $error("wake outside power save");
	a_sleep_sticky: assert property (sleep_flag && !sleep_flag_clr |=> sleep_flag)
		else $error("sleep flag dropped");
	a_idle_sticky: assert property (idle_flag && !idle_flag_clr |=> idle_flag)
		else $error("idle flag dropped");
	a_sleep_entry: assert property (s_enter |=> watchdog_reset_req or s_asleep)
		else $error("sleep entry missed");
endmodule
bind wdt_watchdog_timer wdt_sva #(.RCOSC_TICK_CYCLES(RCOSC_TICK_CYCLES)) u_sva (
	.sys_clk(sys_clk),
	.reset_n(reset_n),
	.forced_enable_cfg(forced_enable_cfg),
	.software_enable_wr(software_enable_wr),
	.software_enable_wdata(software_enable_wdata),
	.device_reset_req(device_reset_req),
	.power_save_instr(power_save_instr),
	.power_save_idle(power_save_idle),
	.timeout_flag_clr(timeout_flag_clr),
	.sleep_flag_clr(sleep_flag_clr),
	.idle_flag_clr(idle_flag_clr),
	.low_power_rc_osc_en(low_power_rc_osc_en),
	.software_enable_bit(software_enable_bit),
	.timeout_flag(timeout_flag),
	.sleep_flag(sleep_flag),
	.idle_flag(idle_flag),
	.power_save_active(power_save_active),
	.core_wake(core_wake),
	.watchdog_reset_req(watchdog_reset_req)
);

//--- test_watchdog_timer.sv
`timescale 1ns/100ps
module test_watchdog_timer;
	import wdt_pkg::*;
	logic sys_clk = 0, reset_n = 0, fe = 0, wd = 1, ps = 0, clr = 0, pwr = 0, idl = 0;
	logic csw = 0, drst = 0, wk = 0, swr = 0, swd = 0, tfc = 0, sfc = 0, ifc = 0;
	logic [3:0] post = 4'h0;
	logic osc, act, swb, tf, sf, idf, psa, win, cw, rr;
	int error_cnt = 0, tests_run = 0, n;
	// oscillator tick every 4 cycles keeps time-outs short
	wdt_watchdog_timer #(.RCOSC_TICK_CYCLES(4)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
		.forced_enable_cfg(fe), .window_disable_cfg(wd), .prescale_select(ps),
		.postscale_select(post), .watchdog_clear_instr(clr), .power_save_instr(pwr),
		.power_save_idle(idl), .clock_switch_done(csw), .device_reset_req(drst),
		.wake_event(wk), .software_enable_wr(swr), .software_enable_wdata(swd),
		.timeout_flag_clr(tfc), .sleep_flag_clr(sfc), .idle_flag_clr(ifc),
		.low_power_rc_osc_en(osc), .watchdog_active(act), .software_enable_bit(swb),
		.timeout_flag(tf), .sleep_flag(sf), .idle_flag(idf), .power_save_active(psa),
		.window_open(win), .core_wake(cw), .watchdog_reset_req(rr));
	initial forever #2.5 sys_clk = ~sys_clk;
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	task automatic cyc(int k);
		repeat (k) @(negedge sys_clk);
	endtask
	task automatic pl(ref logic s);
		s = 1'h1;
		cyc(1);
		s = 1'h0;
	endtask
	// counts cycles to the next wake or reset pulse
	task automatic wev(int lim, bit quiet);
		n = 0;
		while (cw !== 1'h1 && rr !== 1'h1 && n < lim) begin
			cyc(1);
			n++;
		end
		if (!quiet && n >= lim) begin
			error_cnt++;
			conclude();
		end
	endtask
	// tolerance covers the free-running oscillator phase
	task automatic per(int p);
		chk("period", n > p - 8 && n < p + 12, 1'h1);
	endtask
	task automatic conclude();
		$display("errors %0d comparisons %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		chk("outputs", {osc, act, swb, tf, sf, idf, psa, win, cw, rr}, 10'h000);
	endtask
	task automatic t_ratio();
		swd = 1'h1;
		pl(swr);
		chk("osc", osc, 1'h1);
		chk("swb", swb, 1'h1);
		cyc(1);
		chk("act", act, 1'h1);
		for (int i = 0; i < 4; i++) begin
			ps = i[0];
			post = 4'(i >> 1);
			pl(clr);
			wev(1200, 0);
			per((ps ? 128 : 32) * (1 << post) * 4);
			chk("rr", rr, 1'h1);
			chk("tf", tf, 1'h1);
		end
		cyc(3);
		chk("tf held", tf, 1'h1);
		pl(tfc);
		chk("tf clr", tf, 1'h0);
	endtask
	task automatic t_restart();
		ps = 1'h0;
		post = 4'h0;
		for (int k = 0; k < 2; k++) begin
			pl(clr);
			cyc(96);
			if (k == 0) pl(clr);
			else pl(csw);
			chk("no window", rr, 1'h0);
			wev(300, 0);
			per(128);
		end
	endtask
	task automatic t_enable();
		pl(drst);
		chk("swb", swb, 1'h0);
		wev(400, 1);
		chk("quiet", n, 400);
		chk("osc off", osc, 1'h0);
		chk("act off", act, 1'h0);
		fe = 1'h1;
		swd = 1'h0;
		pl(swr);
		pl(clr);
		wev(300, 0);
		chk("forced", rr, 1'h1);
		chk("osc on", osc, 1'h1);
		fe = 1'h0;
		pl(tfc);
	endtask
	task automatic t_save();
		swd = 1'h1;
		pl(swr);
		for (int k = 0; k < 2; k++) begin
			idl = k[0];
			pl(clr);
			cyc(96);
			pl(pwr);
			chk("psa", psa, 1'h1);
			chk("mode flag", k ? idf : sf, 1'h1);
			wev(300, 0);
			per(128);
			chk("wake", {cw, rr, psa}, 3'h4);
			cyc(2);
			chk("flag kept", k ? idf : sf, 1'h1);
			pl(pwr);
			cyc(96);
			pl(wk);
			chk("other wake", {cw, psa}, 2'h2);
			// step past the wake pulse so the wait below sees the next event
			cyc(1);
			wev(300, 0);
			per(128);
			chk("run reset", rr, 1'h1);
		end
		pl(sfc);
		pl(ifc);
		chk("flags clr", {sf, idf}, 2'h0);
		pl(tfc);
	endtask
	task automatic t_window();
		pl(clr);
		wd = 1'h0;
		cyc(32);
		pl(clr);
		chk("early", rr, 1'h1);
		cyc(111);
		chk("window", win, 1'h1);
		pl(clr);
		chk("late", rr, 1'h0);
		wev(300, 0);
		per(128);
		wd = 1'h1;
		pl(tfc);
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		cyc(10);
		reset_n = 1'h1;
		cyc(1);
		t_reset();
		t_ratio();
		t_restart();
		t_enable();
		t_save();
		t_window();
		conclude();
	end
endmodule
